// ### src/lcc_cell.sv
// One logic cell: four-input table, carry-select pair and register.
// Assumes ticks and controls arrive already selected and gated.
`timescale 1ns/1ps
module lcc_cell import lcc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [31:0] cfg_i,
    input wire logic [3:0] data_i,
    input wire logic lut_chain_i,
    input wire logic reg_chain_i,
    input wire logic cin0_i,
    input wire logic cin1_i,
    input wire logic csel_i,
    input wire logic addsub_i,
    input wire logic tick_a_i,
    input wire logic tick_b_i,
    input wire logic aclr_a_i,
    input wire logic aclr_b_i,
    input wire logic aload_i,
    input wire logic sclr_i,
    input wire logic sload_i,
    input wire logic dev_rst_i,
    output logic comb_o,
    output logic q_o,
    output logic out_a_o,
    output logic out_b_o,
    output logic out_l_o,
    output logic cout0_o,
    output logic cout1_o
);
    // Carry of a one-bit full add
    function automatic logic carry(input logic a, input logic b, input logic c);
        carry = (a & b) | ((a ^ b) & c);
    endfunction : carry

    logic q; // Cell register
    logic next_q; // Register next value
    logic ff_val; // Value the flip-flop type asks for
    wire [15:0] mask = cfg_i[CF_MASK_LSB +: 16]; // Table contents
    wire arith = cfg_i[CF_ARITH];
    wire tick = cfg_i[CF_CLK_B] ? tick_b_i : tick_a_i;
    wire aclr = cfg_i[CF_CLR_B] ? aclr_b_i : aclr_a_i;
    wire in0 = cfg_i[CF_LUT_CHAIN] ? lut_chain_i : data_i[0];
    wire in3 = cfg_i[CF_FEEDBACK] ? q : data_i[3];
    wire [3:0] idx = {in3, data_i[2:1], in0};
    wire lut_res = mask[idx];
    // Subtract inverts the second operand only in arithmetic mode
    wire op_b = data_i[1] ^ (arith & addsub_i);
    wire sum = data_i[0] ^ op_b ^ (csel_i ? cin1_i : cin0_i);
    wire d = cfg_i[CF_REG_CHAIN] ? reg_chain_i : comb_o;
    wire lcc_ff_e ff = lcc_ff_e'(cfg_i[CF_FF_LSB +: 2]);

    assign comb_o = arith ? sum : lut_res;
    assign cout0_o = carry(data_i[0], op_b, cin0_i);
    assign cout1_o = carry(data_i[0], op_b, cin1_i);
    assign q_o = q;
    // Each output picks table or register on its own
    assign out_a_o = cfg_i[CF_OUT_A] ? q : comb_o;
    assign out_b_o = cfg_i[CF_OUT_B] ? q : comb_o;
    assign out_l_o = cfg_i[CF_OUT_L] ? q : comb_o;

    // Flip-flop flavour; fourth input serves as K or R
    always_comb begin
        unique case (ff)
            FF_D: ff_val = d;
            FF_T: ff_val = q ^ d;
            FF_JK: ff_val = (d & ~q) | (~data_i[3] & q);
            FF_SR: ff_val = data_i[3] ? 1'b0 : (d | q);
        endcase
    end

    // Priority: device reset, clear, async load, then clocked path
    always_comb begin
        next_q = q;
        if (dev_rst_i) begin
            next_q = 1'b0;
        end else if (aclr) begin
            next_q = 1'b0;
        end else if (aload_i) begin
            next_q = data_i[3];
        end else if (tick) begin
            if (sclr_i) begin
                next_q = 1'b0;
            end else if (sload_i) begin
                next_q = data_i[3];
            end else begin
                next_q = ff_val;
            end
        end
    end

    // Register itself; clock enable freezes it
    always_ff @(posedge clk_i) begin
        if (rst_i) q <= 1'b0;
        else if (ce_i) q <= next_q;
    end

    chk_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && aclr && aload_i |=> !q_o) else $error("clear lost to load");
    chk_aload_data: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && aload_i && !aclr && !dev_rst_i |=> q_o == $past(data_i[3]))
        else $error("async load value wrong");
    chk_gate_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !tick && !aclr && !aload_i && !dev_rst_i |=> $stable(q_o))
        else $error("register moved without tick");
    chk_devrst_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && dev_rst_i |=> !q_o) else $error("device reset ignored");
    chk_sclr_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tick && sclr_i && !aclr && !aload_i && !dev_rst_i |=> !q_o)
        else $error("sync clear ignored");
endmodule : lcc_cell

// ### src/lcc_cluster.sv
// Ten-cell logic cluster with its control generator and a Wishbone slave.
// Assumes row clocks and the device reset pin are asynchronous to clk_i;
// cell data and local controls come from logic on clk_i.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Cluster holds ten cells sharing controls
// - Table output chains into the next cell
// - Register output feeds next cell register
// - Ten cluster controls from one generator
// - Each cluster clock uses its own gate
// - Second clock may take the falling edge
// - Low gate stops that clock, registers hold
// - Async load with high data is preset
// - Controls come from row lines or local
// - Cell has four-input table plus register
// - Register acts as D, T, JK or SR
// - Register has data, load, clock, enable, clears
// - Async load value is fourth input
// - Combinational use bypasses the register
// - Three outputs pick table or register each
// - Register may feed its own table
// - Subtract inverts B and forces carry one
// - Lowest bit in first cell gets carry one
// - Normal and arithmetic modes steer eight inputs
// - Controls work in all modes, subtract arithmetic
// - Registered and unregistered forms together
// - Clear beats preset or load
// - Device reset clears all, overrides everything
// - Sync clear and load reach every register
module lcc_cluster import lcc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] row_clock_i,
    input wire logic [9:0] ctl_local_i,
    input wire logic [39:0] cell_data_i,
    input wire logic lut_chain_i,
    input wire logic reg_chain_i,
    input wire logic chain_carry_if_zero_i,
    input wire logic chain_carry_if_one_i,
    input wire logic cluster_carry_i,
    input wire logic device_wide_reset_n_i,
    output logic [9:0] cell_route_a_o,
    output logic [9:0] cell_route_b_o,
    output logic [9:0] cell_local_o,
    output logic lut_chain_o,
    output logic reg_chain_o,
    output logic chain_carry_if_zero_o,
    output logic chain_carry_if_one_o
);
    // Pick one control: bit 3 chooses row line, bits 2:0 the row
    function automatic logic pick_ctl(input logic [3:0] src, input logic [7:0] rows,
                                      input logic loc);
        pick_ctl = src[3] ? rows[src[2:0]] : loc;
    endfunction : pick_ctl

    // Merge a write into a register under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) res[8*b +: 8] = wd[8*b +: 8];
        end
        merge = res;
    endfunction : merge

    // Configuration storage
    logic [31:0] cell_cfg [LCC_CELLS]; // One word per cell
    logic [31:0] src_lo; // Sources of controls 0 to 7
    logic [9:0] src_hi; // Sources of controls 8, 9 and options
    logic ack; // Bus answer
    logic [31:0] rdata; // Registered read data

    // Pin synchronisers
    logic [7:0] row_meta; // First stage, read only by second
    logic [7:0] row_sync; // Row lines safe to use
    logic devrst_meta; // First stage of reset pin
    logic devrst_n_sync; // Reset pin safe to use

    // Edge history of the two cluster clocks
    logic clk_a_prev;
    logic clk_b_prev;

    // Registered cluster outputs
    logic [9:0] route_a;
    logic [9:0] route_b;
    logic [9:0] route_l;
    logic lut_last;
    logic reg_last;
    logic cout0_last;
    logic cout1_last;

    // Cell interconnect; index i feeds cell i
    wire [LCC_CELLS:0] lut_chain;
    wire [LCC_CELLS:0] reg_chain;
    wire [LCC_CELLS:0] carry0;
    wire [LCC_CELLS:0] carry1;
    wire [LCC_CELLS-1:0] comb_v; // Unregistered cell results
    wire [LCC_CELLS-1:0] q_v; // Cell registers
    wire [LCC_CELLS-1:0] oa_v;
    wire [LCC_CELLS-1:0] ob_v;
    wire [LCC_CELLS-1:0] ol_v;

    // Bus decode
    wire wb_req = cyc_i & stb_i & ~ack;
    wire wb_wr = wb_req & we_i;
    wire [5:0] word = adr_i[7:2];
    wire hit_cell = word < 6'(LCC_CELLS);
    wire [3:0] cell_idx = word[3:0];
    wire hit_lo = adr_i == OFF_SRC_LO;
    wire hit_hi = adr_i == OFF_SRC_HI;
    wire hit_st = adr_i == OFF_STATUS;

    // Control generator: ten controls from row lines or local wires
    wire [39:0] src_all = {src_hi[7:0], src_lo};
    logic [LCC_NCTL-1:0] ctl;
    always_comb begin
        for (int c = 0; c < LCC_NCTL; c++) begin
            ctl[c] = pick_ctl(src_all[4*c +: 4], row_sync, ctl_local_i[c]);
        end
    end

    // Clock a always rising; clock b rising or falling by option
    wire clkb_fall = src_hi[HI_CLKB_FALL];
    wire edge_a = ctl[CTL_CLK_A] & ~clk_a_prev;
    wire edge_b = clkb_fall ? (~ctl[CTL_CLK_B] & clk_b_prev)
                            : (ctl[CTL_CLK_B] & ~clk_b_prev);
    // A low gate suppresses the whole cluster-wide tick
    wire tick_a = edge_a & ctl[CTL_GATE_A];
    wire tick_b = edge_b & ctl[CTL_GATE_B];
    wire addsub = ctl[CTL_ADDSUB];
    // Reset pin only acts when software has enabled it
    wire dev_rst = src_hi[HI_DEVRST_EN] & ~devrst_n_sync;

    // Subtract forces the first cell's carry to one on both chains
    assign carry0[0] = addsub | chain_carry_if_zero_i;
    assign carry1[0] = addsub | chain_carry_if_one_i;
    wire csel = addsub | cluster_carry_i;
    assign lut_chain[0] = lut_chain_i;
    assign reg_chain[0] = reg_chain_i;

    // Ten cells, each chained to its neighbour
    for (genvar i = 0; i < LCC_CELLS; i++) begin : g_cell
        lcc_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .cfg_i(cell_cfg[i]),
            .data_i(cell_data_i[4*i +: 4]),
            .lut_chain_i(lut_chain[i]),
            .reg_chain_i(reg_chain[i]),
            .cin0_i(carry0[i]),
            .cin1_i(carry1[i]),
            .csel_i(csel),
            .addsub_i(addsub),
            .tick_a_i(tick_a),
            .tick_b_i(tick_b),
            .aclr_a_i(ctl[CTL_ACLR_A]),
            .aclr_b_i(ctl[CTL_ACLR_B]),
            .aload_i(ctl[CTL_ALOAD]),
            .sclr_i(ctl[CTL_SCLR]),
            .sload_i(ctl[CTL_SLOAD]),
            .dev_rst_i(dev_rst),
            .comb_o(comb_v[i]),
            .q_o(q_v[i]),
            .out_a_o(oa_v[i]),
            .out_b_o(ob_v[i]),
            .out_l_o(ol_v[i]),
            .cout0_o(carry0[i+1]),
            .cout1_o(carry1[i+1])
        );
        assign lut_chain[i+1] = comb_v[i];
        assign reg_chain[i+1] = q_v[i];
    end

    // Status word: registers, table results, chain carries, reset
    wire [31:0] status = {9'h000, dev_rst, carry1[LCC_CELLS], carry0[LCC_CELLS],
                          comb_v, q_v};
    wire [31:0] cell_word = hit_cell ? cell_cfg[cell_idx] : 32'h0000_0000;
    wire [31:0] read_mux = hit_cell ? cell_word
                         : hit_lo ? src_lo
                         : hit_hi ? {22'h000000, src_hi}
                         : hit_st ? status : 32'h0000_0000;

    // Bus answer: one wait state, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else if (ce_i) begin
            ack <= wb_req;
            if (wb_req) rdata <= read_mux;
        end
    end

    // Configuration writes take effect at the edge that raises ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < LCC_CELLS; k++) cell_cfg[k] <= CFG_RST;
            src_lo <= SRC_LO_RST;
            src_hi <= SRC_HI_RST;
        end else if (ce_i && wb_wr) begin
            if (hit_cell) cell_cfg[cell_idx] <= merge(cell_cfg[cell_idx], dat_i, sel_i);
            if (hit_lo) src_lo <= merge(src_lo, dat_i, sel_i);
            if (hit_hi) src_hi <= 10'(merge({22'h000000, src_hi}, dat_i, sel_i));
        end
    end

    // Two-stage synchronisers for asynchronous pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_meta <= 8'h00;
            row_sync <= 8'h00;
            devrst_meta <= 1'b1;
            devrst_n_sync <= 1'b1;
        end else if (ce_i) begin
            row_meta <= row_clock_i;
            row_sync <= row_meta;
            devrst_meta <= device_wide_reset_n_i;
            devrst_n_sync <= devrst_meta;
        end
    end

    // Clock history for edge detection; reads synced row lines or local controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_a_prev <= 1'b0;
            clk_b_prev <= 1'b0;
        end else if (ce_i) begin
            clk_a_prev <= ctl[CTL_CLK_A];
            clk_b_prev <= ctl[CTL_CLK_B];
        end
    end

    // Outputs are registered so routing sees clean levels;
    // this costs one cycle of latency on every cell output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_a <= 10'h000;
            route_b <= 10'h000;
            route_l <= 10'h000;
            lut_last <= 1'b0;
            reg_last <= 1'b0;
            cout0_last <= 1'b0;
            cout1_last <= 1'b0;
        end else if (ce_i) begin
            route_a <= oa_v;
            route_b <= ob_v;
            route_l <= ol_v;
            lut_last <= lut_chain[LCC_CELLS];
            reg_last <= reg_chain[LCC_CELLS];
            cout0_last <= carry0[LCC_CELLS];
            cout1_last <= carry1[LCC_CELLS];
        end
    end

    assign dat_o = rdata;
    assign ack_o = ack;
    assign cell_route_a_o = route_a;
    assign cell_route_b_o = route_b;
    assign cell_local_o = route_l;
    assign lut_chain_o = lut_last;
    assign reg_chain_o = reg_last;
    assign chain_carry_if_zero_o = cout0_last;
    assign chain_carry_if_one_o = cout1_last;

    chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held two cycles");
    chk_gate_a_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl[CTL_GATE_A] |-> !tick_a) else $error("tick a without gate");
    chk_fall_edge_b: assert property (@(posedge clk_i) disable iff (rst_i)
        clkb_fall && tick_b |-> !ctl[CTL_CLK_B] && $past(ctl[CTL_CLK_B], 1) && ce_i)
        else $error("falling tick b wrong");
    chk_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        addsub |-> carry0[0] && carry1[0] && csel) else $error("subtract carry not one");
    chk_shift_chain: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && tick_a && !dev_rst && !ctl[CTL_ACLR_A] && !ctl[CTL_ALOAD]
        && !ctl[CTL_SCLR] && !ctl[CTL_SLOAD] && cell_cfg[1][CF_REG_CHAIN]
        && !cell_cfg[1][CF_CLK_B] && !cell_cfg[1][CF_CLR_B]
        && cell_cfg[1][CF_FF_LSB +: 2] == 2'b00 |=> q_v[1] == $past(q_v[0]))
        else $error("register chain shift wrong");
    chk_route_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cell_cfg[0][CF_OUT_A] |=> cell_route_a_o[0] == $past(q_v[0]))
        else $error("route a not from register");
endmodule : lcc_cluster

// ### src/lcc_pkg.sv
// Constants shared by the logic cluster top and its cells.
// Assumes a 32-bit classic Wishbone register bus with byte offsets.
package lcc_pkg;
    // Cluster size and control count
    localparam int LCC_CELLS = 10;
    localparam int LCC_NCTL = 10;
    localparam int LCC_ROWS = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CELL0 = 8'h00;
    localparam logic [7:0] OFF_SRC_LO = 8'h28;
    localparam logic [7:0] OFF_SRC_HI = 8'h2c;
    localparam logic [7:0] OFF_STATUS = 8'h30;
    // Reset values
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] SRC_LO_RST = 32'h0000_0000;
    localparam logic [9:0] SRC_HI_RST = 10'h000;
    // Cell configuration fields
    localparam int CF_MASK_LSB = 0;
    localparam int CF_CLK_B = 16;
    localparam int CF_CLR_B = 17;
    localparam int CF_FF_LSB = 18;
    localparam int CF_ARITH = 20;
    localparam int CF_FEEDBACK = 21;
    localparam int CF_OUT_A = 22;
    localparam int CF_OUT_B = 23;
    localparam int CF_OUT_L = 24;
    localparam int CF_LUT_CHAIN = 25;
    localparam int CF_REG_CHAIN = 26;
    // High source register extras
    localparam int HI_CLKB_FALL = 8;
    localparam int HI_DEVRST_EN = 9;
    // Control indices within the selected control vector
    localparam int CTL_CLK_A = 0;
    localparam int CTL_CLK_B = 1;
    localparam int CTL_GATE_A = 2;
    localparam int CTL_GATE_B = 3;
    localparam int CTL_ACLR_A = 4;
    localparam int CTL_ACLR_B = 5;
    localparam int CTL_SCLR = 6;
    localparam int CTL_ALOAD = 7;
    localparam int CTL_SLOAD = 8;
    localparam int CTL_ADDSUB = 9;
    // Register behaviour of a cell
    typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcc_ff_e;
endpackage : lcc_pkg

// ### tb/lcc_row_source.sv
// Row-line and device-reset driver standing in for the surrounding user logic.
// Assumes the bench requests levels; lines follow one cycle later, three if slow.
`timescale 1ns/1ps
module lcc_row_source (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [7:0] row_req_i,
    input wire logic rst_req_i,
    output logic [7:0] row_o,
    output logic device_wide_reset_n_o
);
    // Lag line; slow mode answers from its last stage
    logic [8:0] lag [3];
    // Requests ripple along, so prompt and late answers both occur
    always_ff @(posedge clk_i) begin
        lag[0] <= {rst_req_i, row_req_i};
        lag[1] <= lag[0];
        lag[2] <= lag[1];
    end
    // Row lines feed cluster controls
    assign row_o = slow_i ? lag[2][7:0] : lag[0][7:0];
    // Reset pin is active low on the wire
    assign device_wide_reset_n_o = ~(slow_i ? lag[2][8] : lag[0][8]);
endmodule : lcc_row_source

// ### tb/tb_logic_cluster_cells.sv
// Self-checking bench for the ten-cell cluster with a behavioural model.
// Assumes the Wishbone slave answers with ack and cell outputs lag q by one.
`timescale 1ns/1ps
module tb_logic_cluster_cells import lcc_pkg::*; ;
    localparam logic [31:0] OUTS = 32'h0140_0000; // Out a and local show q
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, lco, rco, c0o, c1o, dev_n;
    logic [9:0] ctl = 10'h000; // Local control sources
    logic [9:0] cs = 10'h000; // Shadow of ctl
    logic [39:0] data = 40'h0;
    logic lchain = 1'b0, rchain = 1'b0, cz = 1'b0, co = 1'b0, csel = 1'b0;
    logic slow = 1'b0, rst_req = 1'b0;
    logic ce = 1'b1; // Cluster clock enable, dropped once to prove the freeze
    logic [7:0] row_req = 8'h00, rows;
    logic [9:0] ra, rb, rl;
    logic [31:0] mcfg [10]; // Model of cell configuration
    logic [9:0] mq = 10'h000; // Model of cell registers
    int n_mismatch = 0;
    int cmp_count = 0;
    // 50 MHz clock
    initial forever #10 clk_i = ~clk_i;
    lcc_cluster dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
        .row_clock_i(rows), .ctl_local_i(ctl), .cell_data_i(data), .lut_chain_i(lchain),
        .reg_chain_i(rchain), .chain_carry_if_zero_i(cz), .chain_carry_if_one_i(co),
        .cluster_carry_i(csel), .device_wide_reset_n_i(dev_n), .cell_route_a_o(ra),
        .cell_route_b_o(rb), .cell_local_o(rl), .lut_chain_o(lco), .reg_chain_o(rco),
        .chain_carry_if_zero_o(c0o), .chain_carry_if_one_o(c1o));
    lcc_row_source u_rows (.clk_i(clk_i), .slow_i(slow), .row_req_i(row_req),
        .rst_req_i(rst_req), .row_o(rows), .device_wide_reset_n_o(dev_n));
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle
    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack_o !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic setcfg(input int i, input logic [31:0] v);
        mcfg[i] = v;
        wb(1'b1, 8'(4 * i), v, 4'hf, rd);
    endtask : setcfg
    // Model of the table, with chain and feedback inputs
    function automatic logic lut_m(int i);
        logic [3:0] x;
        x = data[4 * i +: 4];
        if (mcfg[i][CF_LUT_CHAIN]) x[0] = (i == 0) ? lchain : lut_m(i - 1);
        if (mcfg[i][CF_FEEDBACK]) x[3] = mq[i];
        return mcfg[i][x];
    endfunction : lut_m
    function automatic logic [9:0] luts_m();
        logic [9:0] u;
        for (int i = 0; i < LCC_CELLS; i++) u[i] = lut_m(i);
        return u;
    endfunction : luts_m
    // Next register value on a tick; clear beats load
    function automatic logic next_m(int i, logic sc, logic sl);
        logic d, k;
        d = mcfg[i][CF_REG_CHAIN] ? ((i == 0) ? rchain : mq[i - 1]) : lut_m(i);
        k = data[4 * i + 3];
        if (sc) return 1'b0;
        if (sl) return k;
        case (mcfg[i][19:18])
            2'h1: return mq[i] ^ d;
            2'h2: return (d & ~mq[i]) | (~k & mq[i]);
            2'h3: return k ? 1'b0 : (d | mq[i]);
            default: return d;
        endcase
    endfunction : next_m
    // Edge on clock source b with gate g and the sync controls held across it
    task automatic pulse(input int b, input logic g, input logic sc, input logic sl);
        logic [9:0] nq;
        cs[CTL_GATE_A + b] = g;
        cs[CTL_SCLR] = sc;
        cs[CTL_SLOAD] = sl;
        ctl <= cs;
        @(posedge clk_i);
        cs[b] = 1'b1;
        ctl <= cs;
        idle(2);
        cs[b] = 1'b0;
        cs[CTL_SCLR] = 1'b0;
        cs[CTL_SLOAD] = 1'b0;
        ctl <= cs;
        idle(2);
        nq = mq;
        for (int i = 0; i < LCC_CELLS; i++) begin
            if (g && mcfg[i][CF_CLK_B] == b[0]) nq[i] = next_m(i, sc, sl);
        end
        mq = nq;
    endtask : pulse
    // Clear a and async load, no tick needed; clear wins
    task automatic async(input logic clr, input logic ld);
        cs[CTL_ACLR_A] = clr;
        cs[CTL_ALOAD] = ld;
        ctl <= cs;
        idle(3);
        cs[CTL_ACLR_A] = 1'b0;
        cs[CTL_ALOAD] = 1'b0;
        ctl <= cs;
        idle(2);
        for (int i = 0; i < LCC_CELLS; i++) begin
            if (clr && !mcfg[i][CF_CLR_B]) mq[i] = 1'b0;
            else if (ld) mq[i] = data[4 * i + 3];
        end
    endtask : async
    task automatic look();
        logic [9:0] u;
        u = luts_m();
        wb(1'b0, OFF_STATUS, 32'h0, 4'hf, rd);
        chk(32'(rd[9:0]), 32'(mq));
        chk(32'(rd[19:10]), 32'(u));
        chk(32'(ra), 32'(mq));
        chk(32'(rb), 32'(u));
        chk(32'(rl), 32'(mq));
        chk(32'(rco), 32'(mq[9]));
        chk(32'(lco), 32'(u[9]));
    endtask : look
    // Random table, clock, clear and register kind; feedback only on D
    task automatic rand_cfg();
        logic [31:0] v;
        for (int i = 0; i < LCC_CELLS; i++) begin
            v = OUTS | ($urandom() & 32'h000f_ffff);
            if (v[19:18] == 2'h0) v[CF_FEEDBACK] = 1'($urandom());
            setcfg(i, v);
        end
        data <= 40'({$urandom(), $urandom()});
        idle(3);
    endtask : rand_cfg
    // Hang guard
    initial begin
        idle(60000);
        n_mismatch++;
        close_out();
    end
    initial begin
        logic [9:0] a, b;
        logic [10:0] e;
        logic [39:0] d;
        logic as, c;
        void'($urandom(85));
        for (int i = 0; i < LCC_CELLS; i++) mcfg[i] = 32'h0;
        idle(20);
        rst_i <= 1'b0;
        for (int i = 0; i <= 44; i += 4) begin
            wb(1'b0, 8'(i), 32'h0, 4'hf, rd);
            chk(rd, 32'h0); // reset value
        end
        wb(1'b1, 8'h34, 32'hffff_ffff, 4'hf, rd);
        wb(1'b0, 8'h34, 32'h0, 4'hf, rd);
        chk(rd, 32'h0); // unmapped place
        wb(1'b1, OFF_CELL0, 32'h1234_5678, 4'h1, rd);
        wb(1'b0, OFF_CELL0, 32'h0, 4'hf, rd);
        chk(rd, 32'h78); // byte lane
        repeat (3) begin
            rand_cfg();
            look();
        end
        for (int i = 0; i < LCC_CELLS; i++) setcfg(i, OUTS | 32'h0200_aaaa);
        for (int v = 0; v < 2; v++) begin
            lchain <= 1'(v);
            idle(3);
            look();
        end
        repeat (4) begin
            rand_cfg();
            pulse(0, 1'($urandom()), 1'b0, 1'b0);
            look();
            pulse(1, 1'b1, 1'b0, 1'b0);
            look();
        end
        // A tick while the enable is low must leave every register alone
        a = mq;
        ce <= 1'b0;
        pulse(0, 1'b1, 1'b0, 1'b0);
        mq = a;
        ce <= 1'b1;
        look();
        rand_cfg();
        async(1'b0, 1'b1);
        look();
        async(1'b1, 1'b1);
        look();
        async(1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            pulse(0, k < 3, k != 1, k != 0);
            look();
        end
        for (int i = 0; i < LCC_CELLS; i++) setcfg(i, OUTS | 32'h0400_0000);
        repeat (12) begin
            rchain <= 1'($urandom());
            pulse(0, 1'b1, 1'b0, 1'b0);
            look();
        end
        for (int i = 0; i < LCC_CELLS; i++) setcfg(i, OUTS | 32'h0010_0000);
        repeat (12) begin
            a = 10'($urandom());
            b = 10'($urandom());
            as = 1'($urandom());
            {cz, co, csel} <= 3'($urandom());
            d = 40'({$urandom(), $urandom()});
            for (int i = 0; i < LCC_CELLS; i++) d[4 * i +: 2] = {b[i], a[i]};
            data <= d;
            cs[CTL_ADDSUB] = as;
            ctl <= cs;
            idle(3);
            c = as ? 1'b1 : (csel ? co : cz);
            e = a + (as ? ~b : b) + c;
            wb(1'b0, OFF_STATUS, 32'h0, 4'hf, rd);
            chk(32'(rd[19:10]), 32'(e[9:0]));
        end
        cs[CTL_ADDSUB] = 1'b0;
        for (int i = 0; i < LCC_CELLS; i++) setcfg(i, OUTS);
        data <= {10{4'h8}};
        wb(1'b1, OFF_SRC_LO, 32'h000d_0000, 4'hf, rd);
        async(1'b0, 1'b1);
        slow <= 1'b1;
        row_req <= 8'h20;
        idle(8);
        row_req <= 8'h00;
        idle(4);
        mq = 10'h000;
        look();
        async(1'b0, 1'b1);
        slow <= 1'b0;
        wb(1'b1, OFF_SRC_HI, 32'h0000_0200, 4'hf, rd);
        rst_req <= 1'b1;
        idle(6);
        rst_req <= 1'b0;
        idle(4);
        mq = 10'h000;
        look();
        close_out();
    end
endmodule : tb_logic_cluster_cells
